// File: core/nand_consts.svh
// Timing, geometry and command constants of the NAND page read controller.
`ifndef NAND_CONSTS_SVH
`define NAND_CONSTS_SVH

`define NAND_CLK_NS         50
`define NAND_T_WB_NS        100
`define NAND_T_WHR_NS       60
`define NAND_T_REA_NS       20
`define NAND_T_RR_NS        20
`define NAND_SYNC           2
`define NAND_CEIL(ns)       (((ns) + `NAND_CLK_NS - 1) / `NAND_CLK_NS)
`define NAND_WB_WAIT        4'(`NAND_CEIL(`NAND_T_WB_NS) + `NAND_SYNC + 1)
`define NAND_WHR_WAIT       4'(`NAND_CEIL(`NAND_T_WHR_NS))
`define NAND_RR_WAIT        4'(`NAND_CEIL(`NAND_T_RR_NS))
`define NAND_RD_LOW_WAIT    4'(`NAND_CEIL(`NAND_T_REA_NS) + `NAND_SYNC)

`define NAND_PAGE_BYTES     13'h0840
`define NAND_MAIN_BYTES     13'h0800
`define NAND_SPARE_BYTES    13'h0040
`define NAND_PAGES_PER_BLK  7'h40
`define NAND_BLOCKS         12'h0800
`define NAND_BLK_LSB        6
`define NAND_ECC_BYTES      12'h0004
`define NAND_FIFO_DEPTH     32

`define NAND_CMD_READ       8'h00
`define NAND_CMD_READ_GO    8'h30
`define NAND_CMD_CACHE_GO   8'h35
`define NAND_CMD_COL_RD     8'h05
`define NAND_CMD_COL_RD_GO  8'hE0
`define NAND_CMD_PROG       8'h80
`define NAND_CMD_PROG_2ND   8'h81
`define NAND_CMD_COL_WR     8'h85
`define NAND_CMD_PROG_GO    8'h10
`define NAND_CMD_PROG_MID   8'h11
`define NAND_CMD_SELECT     8'h60
`define NAND_CMD_ERASE_GO   8'hD0
`define NAND_CMD_ID         8'h90
`define NAND_CMD_STATUS     8'h70
`define NAND_CMD_STATUS2    8'h71
`define NAND_CMD_ECC        8'h7A
`define NAND_CMD_RESET      8'hFF

`endif

// File: core/nand_pkg.sv
// Operation, sequencer state and descriptor types of the NAND page read controller.
package nand_pkg;
    typedef enum logic [3:0] {OP_READ, OP_READ_DUAL, OP_COL_CHANGE, OP_COPY_SRC, OP_COPY_DST,
        OP_ERASE, OP_STATUS, OP_STATUS_DUAL, OP_ECC_STATUS, OP_ID, OP_RESET} nand_op_e;
    typedef enum logic [3:0] {S_IDLE, S_CMD1, S_ADDR, S_CMD2, S_WAIT_WB, S_WAIT_RDY, S_GAP,
        S_RD_HIGH, S_RD_LOW, S_FINISH} seq_state_e;
    typedef struct packed {
        logic [7:0] c1;
        logic [7:0] c2;
        logic       has_c2;
        logic       has_addr;
        logic [2:0] first;
        logic [2:0] last;
        logic       wait_busy;
    } op_desc_s;
endpackage

// File: core/fifo_if.sv
// Valid/ready byte stream between the sequencer and its read buffer.
`timescale 1ns/1ns
`default_nettype none
interface fifo_if #(parameter int WIDTH = 8) ();
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: core/byte_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic core_clk,  // System clock.
    input  wire logic reset,     // Synchronous reset, active high.
    fifo_if.sink      in_if,     // Filling side.
    fifo_if.source    out_if     // Draining side.
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    rd_ptr_ff;
    logic [PW:0]      count_ff;
    wire              push = in_if.valid && in_if.ready;
    wire              pop  = out_if.valid && out_if.ready;

    assign in_if.ready  = count_ff != (PW+1)'(DEPTH);
    assign out_if.valid = count_ff != '0;
    assign out_if.data  = mem_ff[rd_ptr_ff];

    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge core_clk) begin
            if (push && wr_ptr_ff == PW'(i)) begin
                mem_ff[i] <= in_if.data;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            wr_ptr_ff <= wr_ptr_ff + PW'(push);
            rd_ptr_ff <= rd_ptr_ff + PW'(pop);
            count_ff  <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule // byte_fifo
`default_nettype wire

// File: core/nand_page_reader.sv
// Host-side controller that drives a NAND flash through its pins.
`timescale 1ns/1ns
`default_nettype none
`include "nand_consts.svh"

// Overview of operation
// - Address goes in five consecutive cycles; erase three, column change two, ID one.
// - Column bytes, then three page bytes, upper zero.
// - Latch and strobe levels select cycle type.
// - Strobes held high during read busy.
// - Read 00/30; column change 05/E0.
// - Program 80/10, 85 column, dual 11/81; no program operation is issued, only 85/10 for copy-back.
// - Copy-back 00/35 then 85/10; erase 60/D0.
// - Single codes 90, 70, 71, 7A, FF.
// - Dual read addresses share page bits 0-5.
// - ECC status only after single page read; refused only when the last page read was dual.
module nand_page_reader #(
    parameter int FIFO_DEPTH = `NAND_FIFO_DEPTH
) (
    input  wire logic               core_clk,     // System clock, 20 MHz.
    input  wire logic               reset,        // Synchronous reset, active high.
    input  wire logic               cmd_valid,    // Operation request.
    output logic                    cmd_ready,    // Request can be taken.
    input  wire nand_pkg::nand_op_e cmd_op,       // Operation to run.
    input  wire logic [11:0]        cmd_col,      // Start column.
    input  wire logic [16:0]        cmd_page,     // Page address, first district.
    input  wire logic [16:0]        cmd_page_b,   // Page address, second district.
    input  wire logic [11:0]        cmd_len,      // Bytes to read.
    input  wire logic               wp_release,   // Drive write protect high.
    output logic                    rd_valid,     // Read byte available.
    input  wire logic               rd_ready,     // Read byte consumed.
    output logic [7:0]              rd_data,      // Read byte.
    output logic                    done_pulse,   // Operation finished.
    output logic                    error_pulse,  // Request rejected.
    output logic [11:0]             cur_column,   // Mirror of the column counter.
    output logic                    ce_n,         // Chip select, active low.
    output logic                    cle,          // Command latch.
    output logic                    ale,          // Address latch.
    output logic                    we_n,         // Write strobe, active low.
    output logic                    re_n,         // Read strobe, active low.
    output logic                    wp_n,         // Write protect, active low.
    output logic [7:0]              io_out,       // Shared port lines, driven value.
    output logic                    io_oe,        // Shared port lines, drive enable.
    input  wire logic [7:0]         io_in,        // Shared port lines, sensed value.
    input  wire logic               ready_busy_n  // Ready/busy line, low while busy.
);
    // =====================================================================
    // Declarations
    nand_pkg::seq_state_e st_ff, nxt_st;
    nand_pkg::nand_op_e   op_ff;
    nand_pkg::op_desc_s   desc;
    logic        half_ff, second_ff, nxt_second, last_dual_ff, done_ff, error_ff;
    logic [2:0]  idx_ff, nxt_idx, ale_cnt_ff;
    logic [3:0]  wait_ff, nxt_wait, tail_wait;
    logic [11:0] col_ff, left_ff, acc_len;
    logic [16:0] page_a_ff, page_b_ff, pg;
    logic [7:0]  io_s1_ff, io_s2_ff, addr_byte;
    logic        rb_s1_ff, rb_s2_ff;
    logic [12:0] col_end;
    nand_pkg::seq_state_e tail_st;
    wire         wr_state = st_ff inside {nand_pkg::S_CMD1, nand_pkg::S_ADDR, nand_pkg::S_CMD2};
    wire         busy_ok  = cmd_op inside {nand_pkg::OP_STATUS, nand_pkg::OP_STATUS_DUAL, nand_pkg::OP_RESET};
    wire         uses_col = cmd_op inside {nand_pkg::OP_READ, nand_pkg::OP_READ_DUAL, nand_pkg::OP_COL_CHANGE};
    wire         col_trk  = op_ff inside {nand_pkg::OP_READ, nand_pkg::OP_READ_DUAL, nand_pkg::OP_COL_CHANGE};
    wire         take, bad, bad_range, bad_dual, bad_ecc, bad_wp, push;
    fifo_if #(.WIDTH(8)) wr_if ();
    fifo_if #(.WIDTH(8)) rd_if ();

    // =====================================================================
    // Pin synchronisers
    always_ff @(posedge core_clk) begin
        rb_s1_ff <= ready_busy_n;
        rb_s2_ff <= rb_s1_ff;
        io_s1_ff <= io_in;
        io_s2_ff <= io_s1_ff;
    end

    // =====================================================================
    // Request decode and checks
    assign acc_len   = uses_col || cmd_op == nand_pkg::OP_ID ? cmd_len
                     : busy_ok && cmd_op != nand_pkg::OP_RESET ? 12'h001
                     : cmd_op == nand_pkg::OP_ECC_STATUS ? `NAND_ECC_BYTES : 12'h000;
    assign col_end   = {1'b0, cmd_col} + {1'b0, acc_len};
    assign bad_range = uses_col && col_end > `NAND_PAGE_BYTES;
    assign bad_dual  = cmd_op == nand_pkg::OP_READ_DUAL
                     && (cmd_page[`NAND_BLK_LSB-1:0] != cmd_page_b[`NAND_BLK_LSB-1:0]
                     || cmd_page[`NAND_BLK_LSB] == cmd_page_b[`NAND_BLK_LSB]);
    assign bad_ecc   = cmd_op == nand_pkg::OP_ECC_STATUS && last_dual_ff;
    assign bad_wp    = !wp_release && cmd_op inside {nand_pkg::OP_COPY_DST, nand_pkg::OP_ERASE,
                                                     nand_pkg::OP_READ_DUAL};
    assign bad       = bad_range || bad_dual || bad_ecc || bad_wp;
    assign cmd_ready = st_ff == nand_pkg::S_IDLE && (rb_s2_ff || busy_ok);
    assign take      = cmd_valid && cmd_ready;

    // =====================================================================
    // Operation descriptors
    always_comb begin
        unique case (op_ff)
            nand_pkg::OP_READ:        desc = '{`NAND_CMD_READ, `NAND_CMD_READ_GO, 1'b1, 1'b1, 3'h0, 3'h4, 1'b1};
            nand_pkg::OP_READ_DUAL:   desc = '{`NAND_CMD_SELECT, `NAND_CMD_READ_GO, 1'b1, 1'b1, 3'h0, 3'h4, 1'b1};
            nand_pkg::OP_COL_CHANGE:  desc = '{`NAND_CMD_COL_RD, `NAND_CMD_COL_RD_GO, 1'b1, 1'b1, 3'h0, 3'h1, 1'b0};
            nand_pkg::OP_COPY_SRC:    desc = '{`NAND_CMD_READ, `NAND_CMD_CACHE_GO, 1'b1, 1'b1, 3'h0, 3'h4, 1'b1};
            nand_pkg::OP_COPY_DST:    desc = '{`NAND_CMD_COL_WR, `NAND_CMD_PROG_GO, 1'b1, 1'b1, 3'h0, 3'h4, 1'b1};
            nand_pkg::OP_ERASE:       desc = '{`NAND_CMD_SELECT, `NAND_CMD_ERASE_GO, 1'b1, 1'b1, 3'h2, 3'h4, 1'b1};
            nand_pkg::OP_STATUS:      desc = '{`NAND_CMD_STATUS, 8'h00, 1'b0, 1'b0, 3'h0, 3'h0, 1'b0};
            nand_pkg::OP_STATUS_DUAL: desc = '{`NAND_CMD_STATUS2, 8'h00, 1'b0, 1'b0, 3'h0, 3'h0, 1'b0};
            nand_pkg::OP_ECC_STATUS:  desc = '{`NAND_CMD_ECC, 8'h00, 1'b0, 1'b0, 3'h0, 3'h0, 1'b0};
            nand_pkg::OP_ID:          desc = '{`NAND_CMD_ID, 8'h00, 1'b0, 1'b1, 3'h0, 3'h0, 1'b0};
            nand_pkg::OP_RESET:       desc = '{`NAND_CMD_RESET, 8'h00, 1'b0, 1'b0, 3'h0, 3'h0, 1'b1};
            default:                  desc = '{`NAND_CMD_RESET, 8'h00, 1'b0, 1'b0, 3'h0, 3'h0, 1'b1};
        endcase
    end

    assign pg        = second_ff ? page_b_ff : page_a_ff;
    assign addr_byte = idx_ff == 3'h0 ? col_ff[7:0]
                     : idx_ff == 3'h1 ? {4'h0, col_ff[11:8]}
                     : idx_ff == 3'h2 ? pg[7:0]
                     : idx_ff == 3'h3 ? pg[15:8] : {7'h00, pg[16]};
    assign tail_st   = desc.wait_busy ? nand_pkg::S_WAIT_WB : nand_pkg::S_GAP;
    assign tail_wait = desc.wait_busy ? `NAND_WB_WAIT : `NAND_WHR_WAIT;
    assign push      = st_ff == nand_pkg::S_RD_LOW && wait_ff == 4'h0;

    // =====================================================================
    // Sequencer
    always_comb begin
        nxt_st     = st_ff;
        nxt_idx    = idx_ff;
        nxt_second = second_ff;
        nxt_wait   = wait_ff != 4'h0 ? wait_ff - 4'h1 : 4'h0;
        unique case (st_ff)
            nand_pkg::S_IDLE: begin
                nxt_second = 1'b0;
                if (take && !bad) begin
                    nxt_st = nand_pkg::S_CMD1;
                end
            end
            nand_pkg::S_CMD1: begin
                nxt_idx = desc.first;
                if (half_ff) begin
                    nxt_st   = desc.has_addr ? nand_pkg::S_ADDR : tail_st;
                    nxt_wait = tail_wait;
                end
            end
            nand_pkg::S_ADDR: begin
                if (half_ff && idx_ff != desc.last) begin
                    nxt_idx = idx_ff + 3'h1;
                end else if (half_ff && op_ff == nand_pkg::OP_READ_DUAL && !second_ff) begin
                    nxt_st     = nand_pkg::S_CMD1;
                    nxt_second = 1'b1;
                end else if (half_ff) begin
                    nxt_st   = desc.has_c2 ? nand_pkg::S_CMD2 : tail_st;
                    nxt_wait = tail_wait;
                end
            end
            nand_pkg::S_CMD2: begin
                if (half_ff) begin
                    nxt_st   = tail_st;
                    nxt_wait = tail_wait;
                end
            end
            nand_pkg::S_WAIT_WB: begin
                if (wait_ff == 4'h0) begin
                    nxt_st = nand_pkg::S_WAIT_RDY;
                end
            end
            nand_pkg::S_WAIT_RDY: begin
                if (rb_s2_ff) begin
                    nxt_st   = nand_pkg::S_GAP;
                    nxt_wait = `NAND_RR_WAIT;
                end
            end
            nand_pkg::S_GAP: begin
                if (wait_ff == 4'h0) begin
                    nxt_st = nand_pkg::S_RD_HIGH;
                end
            end
            nand_pkg::S_RD_HIGH: begin
                if (left_ff == 12'h000) begin
                    nxt_st = nand_pkg::S_FINISH;
                end else if (wr_if.ready) begin
                    nxt_st   = nand_pkg::S_RD_LOW;
                    nxt_wait = `NAND_RD_LOW_WAIT;
                end
            end
            nand_pkg::S_RD_LOW: begin
                if (wait_ff == 4'h0) begin
                    nxt_st = nand_pkg::S_RD_HIGH;
                end
            end
            nand_pkg::S_FINISH: nxt_st = nand_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_ff     <= nand_pkg::S_IDLE;
            half_ff   <= 1'b0;
            idx_ff    <= 3'h0;
            second_ff <= 1'b0;
            wait_ff   <= 4'h0;
        end else begin
            st_ff     <= nxt_st;
            half_ff   <= wr_state && !half_ff;
            idx_ff    <= nxt_idx;
            second_ff <= nxt_second;
            wait_ff   <= nxt_wait;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            op_ff        <= nand_pkg::OP_RESET;
            page_a_ff    <= 17'h0_0000;
            page_b_ff    <= 17'h0_0000;
            col_ff       <= 12'h000;
            left_ff      <= 12'h000;
            last_dual_ff <= 1'b0;
        end else if (take && !bad) begin
            op_ff     <= cmd_op;
            page_a_ff <= cmd_page;
            page_b_ff <= cmd_page_b;
            col_ff    <= cmd_op inside {nand_pkg::OP_STATUS, nand_pkg::OP_STATUS_DUAL, nand_pkg::OP_ECC_STATUS,
                                        nand_pkg::OP_RESET} ? col_ff : cmd_col;
            left_ff   <= acc_len;
            if (cmd_op inside {nand_pkg::OP_READ, nand_pkg::OP_READ_DUAL}) begin
                last_dual_ff <= cmd_op == nand_pkg::OP_READ_DUAL;
            end
        end else if (push) begin
            left_ff <= left_ff - 12'h001;
            col_ff  <= col_trk ? col_ff + 12'h001 : col_ff;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            done_ff  <= 1'b0;
            error_ff <= 1'b0;
        end else begin
            done_ff  <= st_ff == nand_pkg::S_FINISH;
            error_ff <= take && bad;
        end
    end

    // =====================================================================
    // Pin drivers, one cycle behind the sequencer
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ce_n   <= 1'b1;
            cle    <= 1'b0;
            ale    <= 1'b0;
            we_n   <= 1'b1;
            re_n   <= 1'b1;
            wp_n   <= 1'b0;
            io_out <= 8'h00;
            io_oe  <= 1'b0;
        end else begin
            ce_n   <= st_ff == nand_pkg::S_IDLE;
            cle    <= st_ff inside {nand_pkg::S_CMD1, nand_pkg::S_CMD2};
            ale    <= st_ff == nand_pkg::S_ADDR;
            we_n   <= !(wr_state && !half_ff);
            re_n   <= st_ff != nand_pkg::S_RD_LOW;
            wp_n   <= wp_release;
            io_out <= st_ff == nand_pkg::S_CMD1 ? desc.c1 : st_ff == nand_pkg::S_CMD2 ? desc.c2 : addr_byte;
            io_oe  <= wr_state;
        end
    end

    // =====================================================================
    // Read buffer
    assign wr_if.valid = push;
    assign wr_if.data  = io_s2_ff;
    assign rd_valid    = rd_if.valid;
    assign rd_if.ready = rd_ready;
    assign rd_data     = rd_if.data;
    assign done_pulse  = done_ff;
    assign error_pulse = error_ff;
    assign cur_column  = col_ff;

    byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk (core_clk),
        .reset    (reset),
        .in_if    (wr_if),
        .out_if   (rd_if)
    );

    // =====================================================================
    // Checks
    always_ff @(posedge core_clk) begin
        if (reset || st_ff == nand_pkg::S_IDLE) begin
            ale_cnt_ff <= 3'h0;
        end else if (ale && !we_n) begin
            ale_cnt_ff <= ale_cnt_ff + 3'h1;
        end
    end

    sequence s_cmd_byte(logic [7:0] code);
        cle && !we_n && io_oe && io_out == code ##1 cle && we_n;
    endsequence

    chk_standby_idle: assert property (@(posedge core_clk) disable iff (reset)
        st_ff == nand_pkg::S_IDLE && $past(st_ff) == nand_pkg::S_IDLE |-> ce_n)
        else $error("chip select low while idle");
    chk_read_strobe: assert property (@(posedge core_clk) disable iff (reset)
        $fell(re_n) && op_ff == nand_pkg::OP_READ |-> ##2 push ##1 cur_column == $past(cur_column, 3) + 12'h001)
        else $error("read strobe did not yield one byte");
    chk_addr_five: assert property (@(posedge core_clk) disable iff (reset)
        st_ff == nand_pkg::S_CMD2 && !half_ff && op_ff == nand_pkg::OP_READ |-> ale_cnt_ff == 3'h5)
        else $error("page read address not five cycles");
    chk_addr_layout: assert property (@(posedge core_clk) disable iff (reset)
        st_ff == nand_pkg::S_ADDR && (idx_ff == 3'h1 || idx_ff == 3'h4)
        |=> ($past(idx_ff) == 3'h1 ? io_out[7:4] == 4'h0 : io_out[7:1] == 7'h00))
        else $error("address cycle upper lines not low");
    chk_cycle_decode: assert property (@(posedge core_clk) disable iff (reset)
        !we_n |-> cle != ale && re_n && !ce_n && io_oe)
        else $error("write strobe with bad latch levels");
    chk_busy_quiet: assert property (@(posedge core_clk) disable iff (reset)
        st_ff == nand_pkg::S_WAIT_RDY && $past(st_ff) == nand_pkg::S_WAIT_RDY |-> we_n && re_n && !ce_n)
        else $error("strobe moved during busy");
    chk_busy_refuse: assert property (@(posedge core_clk) disable iff (reset)
        take && !rb_s2_ff |-> busy_ok)
        else $error("disallowed command taken while busy");
    chk_read_codes: assert property (@(posedge core_clk) disable iff (reset)
        st_ff == nand_pkg::S_CMD2 && !half_ff && op_ff == nand_pkg::OP_READ |=> s_cmd_byte(`NAND_CMD_READ_GO))
        else $error("page read confirm code wrong");
    chk_dual_pages: assert property (@(posedge core_clk) disable iff (reset)
        st_ff == nand_pkg::S_CMD2 && op_ff == nand_pkg::OP_READ_DUAL
        |-> page_a_ff[5:0] == page_b_ff[5:0] && page_a_ff[6] != page_b_ff[6])
        else $error("dual read addresses mismatched");
    chk_ecc_single: assert property (@(posedge core_clk) disable iff (reset)
        take && cmd_op == nand_pkg::OP_ECC_STATUS |=> error_pulse == $past(last_dual_ff))
        else $error("ECC status after dual read not refused");
    chk_ready_first: assert property (@(posedge core_clk) disable iff (reset)
        $fell(re_n) && !(op_ff inside {nand_pkg::OP_STATUS, nand_pkg::OP_STATUS_DUAL}) |-> $past(rb_s2_ff, 2))
        else $error("data output started while busy");
endmodule // nand_page_reader
`default_nettype wire

// File: test/nand_flash_model.sv
// Behavioural flash device that answers the controller's pins.
`timescale 1ns/1ns
`default_nettype none
module nand_flash_model (
    input  wire logic       ce_n,         // Chip select.
    input  wire logic       cle,          // Command latch.
    input  wire logic       ale,          // Address latch.
    input  wire logic       we_n,         // Write strobe.
    input  wire logic       re_n,         // Read strobe.
    input  wire logic [7:0] io_out,       // Port from controller.
    output logic      [7:0] io_in,        // Port to controller.
    output logic            ready_busy_n  // Pulled-up ready line.
);
    logic [11:0] col  = '0;
    logic [7:0]  cmd  = 8'h00;
    int          acnt = 0;
    initial io_in = 8'h00;
    initial ready_busy_n = 1'b1;
    always @(posedge we_n) begin
        if (!ce_n && cle) begin
            cmd = io_out;
            acnt = 0;
            if (cmd == 8'h30) begin
                #50 ready_busy_n = 1'b0;
                #1000 ready_busy_n = 1'b1;
            end
        end else if (!ce_n && ale) begin
            if (acnt == 0) col[7:0] = io_out;
            if (acnt == 1) col[11:8] = io_out[3:0];
            acnt++;
        end
    end
    always @(negedge re_n) if (!ce_n) begin
        io_in <= #15 col[7:0] ^ 8'hA5;
        col = col + 12'h001;
    end
    always @(posedge re_n) io_in = ~io_in;
endmodule  // nand_flash_model
`default_nettype wire

// File: test/nand_page_reader_tb.sv
// Self-checking bench of the flash page read controller.
`timescale 1ns/1ns
`default_nettype none
module nand_page_reader_tb;
    typedef struct {nand_pkg::nand_op_e op; logic [11:0] col, len; logic [16:0] pg, pb; logic wp, err;} row_s;
    logic               core_clk = 0, reset = 1, cmd_valid = 0, rd_ready = 0, wp_release = 0;
    nand_pkg::nand_op_e cmd_op = nand_pkg::OP_READ;
    logic [11:0]        cmd_col = '0, cmd_len = '0, cur_column;
    logic [16:0]        cmd_page = '0, cmd_page_b = '0;
    logic               cmd_ready, rd_valid, done_pulse, error_pulse, ce_n, cle, ale, we_n, re_n, wp_n, io_oe;
    logic [7:0]         rd_data, io_out, io_in;
    logic               ready_busy_n;
    int                 num_errors = 0, comparisons = 0, n_done = 0, n_err = 0;
    row_s rows [14] = '{
        '{nand_pkg::OP_READ, 12'h0000, 12'h0004, 17'h0_0000, 17'h0_0000, 0, 0},
        '{nand_pkg::OP_READ, 12'h083C, 12'h0004, 17'h0_0041, 17'h0_0000, 0, 0},
        '{nand_pkg::OP_READ, 12'h083D, 12'h0004, 17'h0_0000, 17'h0_0000, 0, 1},
        '{nand_pkg::OP_READ_DUAL, 12'h0000, 12'h0003, 17'h0_0000, 17'h0_0041, 1, 1},
        '{nand_pkg::OP_READ_DUAL, 12'h0005, 12'h0003, 17'h0_0000, 17'h0_0040, 1, 0},
        '{nand_pkg::OP_ECC_STATUS, 12'h0000, 12'h0000, 17'h0_0000, 17'h0_0000, 1, 1},
        '{nand_pkg::OP_READ_DUAL, 12'h0000, 12'h0003, 17'h0_0000, 17'h0_0040, 0, 1},
        '{nand_pkg::OP_COL_CHANGE, 12'h0020, 12'h0003, 17'h0_0000, 17'h0_0000, 0, 0},
        '{nand_pkg::OP_COPY_SRC, 12'h0000, 12'h0000, 17'h0_0080, 17'h0_0000, 0, 0},
        '{nand_pkg::OP_COPY_DST, 12'h0000, 12'h0000, 17'h0_0081, 17'h0_0000, 1, 0},
        '{nand_pkg::OP_ERASE, 12'h0000, 12'h0000, 17'h0_0040, 17'h0_0000, 1, 0},
        '{nand_pkg::OP_ID, 12'h0000, 12'h0000, 17'h0_0000, 17'h0_0000, 0, 0},
        '{nand_pkg::OP_RESET, 12'h0000, 12'h0000, 17'h0_0000, 17'h0_0000, 0, 0},
        '{nand_pkg::OP_ERASE, 12'h0000, 12'h0000, 17'h0_0040, 17'h0_0000, 0, 1}};
    nand_page_reader i_dut (.core_clk, .reset, .cmd_valid, .cmd_ready, .cmd_op, .cmd_col, .cmd_page, .cmd_page_b,
        .cmd_len, .wp_release, .rd_valid, .rd_ready, .rd_data, .done_pulse, .error_pulse, .cur_column, .ce_n, .cle,
        .ale, .we_n, .re_n, .wp_n, .io_out, .io_oe, .io_in, .ready_busy_n);
    nand_flash_model i_flash (.ce_n, .cle, .ale, .we_n, .re_n, .io_out, .io_in, .ready_busy_n);
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) n_done <= n_done + done_pulse;
    always @(posedge core_clk) n_err <= n_err + error_pulse;
    always @(negedge core_clk) if (ready_busy_n === 1'b0) chk(we_n & re_n, 12'h0001);
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d, errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Runs one request, drains its bytes and checks the outcome; stall keeps the reader idle at first.
    task automatic run(input row_s r, input logic stall);
        int t;
        int i;
        int e0;
        int s0;
        e0 = n_err;
        s0 = n_done + n_err;
        @(posedge core_clk);
        #1 cmd_op = r.op;
        {cmd_col, cmd_len, cmd_page, cmd_page_b, wp_release} = {r.col, r.len, r.pg, r.pb, r.wp};
        cmd_valid = 1;
        rd_ready = !stall;
        t = 0;
        do @(negedge core_clk); while (cmd_ready !== 1'b1 && ++t < 5000);
        @(posedge core_clk);
        #1 cmd_valid = 0;
        if (stall) begin
            repeat (1500) @(posedge core_clk);
            chk(rd_valid, 12'h0001);
            #1 rd_ready = 1;
        end
        i = 0;
        t = 0;
        while (i < (r.err ? 0 : r.len) && t++ < 20000) begin
            @(negedge core_clk);
            if (rd_valid === 1'b1) begin
                chk(rd_data, 12'(8'(r.col + i) ^ 8'hA5));
                i++;
            end
        end
        chk(12'(i), r.err ? 12'h000 : r.len);
        t = 0;
        while (n_done + n_err == s0 && t++ < 5000) @(negedge core_clk);
        chk(12'(n_done + n_err - s0), 12'h001);
        chk(12'(n_err - e0), 12'(r.err));
        if (!r.err) chk(cur_column, r.col + r.len);
        repeat (3) @(posedge core_clk);
        chk({ce_n, wp_n}, {1'b1, r.wp});
    endtask
    initial begin
        #(50 * 40000);
        num_errors++;
        final_report();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        chk({ce_n, cle, ale, we_n, re_n, wp_n, io_oe}, 12'h004C);
        #1 reset = 0;
        foreach (rows[k]) run(rows[k], 0);
        run(row_s'{nand_pkg::OP_READ, 12'h0010, 12'h0028, 17'h0_0081, 17'h0_0000, 0, 0}, 1);
        final_report();
    end
endmodule  // nand_page_reader_tb
`default_nettype wire
